// File: hdl/noload_regs.svh
// Register map, field positions and reset values of the no-load detector.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
//
// Contract
// RULE_01: Total no-load when both total magnitudes within thresholds
// RULE_02: Total no-load phase stops total energy and pulses
// RULE_03: Both thresholds negative disables total circuit
// RULE_04: Thresholds scaled against full-scale power constant
// RULE_05: Active/reactive thresholds read zero-padded, sign extended
// RULE_06: Total event sets status bit 0, flags 2:0
// RULE_07: Phase A/B/C flags low/mid/high, one means no-load
// RULE_08: Mask bit 0 pulls line low on total change
// RULE_09: Host reads phase register, then write-one clears
// RULE_10: Fundamental no-load uses same thresholds, suppresses energy
// RULE_11: Fundamental event sets status bit 1, flags 5:3
// RULE_12: Mask bit 1 pulls line low on fundamental change
// RULE_13: Apparent no-load when magnitude within apparent threshold
// RULE_14: Negative apparent threshold disables apparent circuit
// RULE_15: Apparent event sets status bit 2, flags 8:6
// RULE_16: Mask bit 2 pulls line low on apparent change
// RULE_17: Active-only variant: host sets reactive threshold most negative; code then never flags total no-load
// RULE_18: Apparent threshold read zero-padded, sign extended
// RULE_19: Line stays low until host clears status
// RULE_20: Status sets regardless of mask bits
// RULE_21: Re-evaluate per power result, status on flag change
`ifndef NOLOAD_REGS_SVH
`define NOLOAD_REGS_SVH

// ----------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------
`define REG_ACTIVE_THR      4'h0
`define REG_REACTIVE_THR    4'h1
`define REG_APPARENT_THR    4'h2
`define REG_SECOND_STATUS   4'h3
`define REG_SECOND_MASK     4'h4
`define REG_PHASE_NOLOAD    4'h5

// ----------------------------------------------------------------
// Fields, widths and reset values
// ----------------------------------------------------------------
`define THR_WIDTH           24
`define DSP_WIDTH           28
`define FULL_SCALE_POWER    28'h1ff_6a6b
`define THR_RESET           24'h00_0000
`define MASK_RESET          3'h0
`define STAT_TOTAL_BIT      0
`define STAT_FUND_BIT       1
`define STAT_APPARENT_BIT   2
`define FLAGS_TOTAL_LSB     0
`define FLAGS_FUND_LSB      3
`define FLAGS_APPARENT_LSB  6

`endif

// File: hdl/noload_pkg.sv
// Types shared by the no-load detector modules.
// Assumes the constants header is on the include path.
`include "noload_regs.svh"

package noload_pkg;

    // ----------------------------------------------------------------
    // One phase's power results, in DSP units of full-scale power
    // ----------------------------------------------------------------
    typedef struct packed {
        logic signed [27:0] total_act;
        logic signed [27:0] total_react;
        logic signed [27:0] fund_act;
        logic signed [27:0] fund_react;
        logic signed [27:0] apparent;
    } phase_power_type;

    // ----------------------------------------------------------------
    // One register access request from the serial port
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } reg_req_type;

endpackage

// File: hdl/noload_compare.sv
// Compares one phase's power magnitudes against no-load thresholds.
// Assumes thresholds already sign extended to the DSP width.
`timescale 1ns/1ns

module noload_compare
    import noload_pkg::*;
(
    // Power results
    input  wire logic signed [27:0] power_a,
    input  wire logic signed [27:0] power_b,
    // Thresholds
    input  wire logic signed [27:0] thr_a,
    input  wire logic signed [27:0] thr_b,
    // Configuration
    input  wire logic               use_b,
    input  wire logic               circuit_on,
    // Result
    output logic                    noload
);

    // ----------------------------------------------------------------
    // Magnitude, clamped at full-scale power
    // ----------------------------------------------------------------
    // Results beyond full scale compare as full scale
    function automatic logic [27:0] magnitude(input logic signed [27:0] p);
        logic [27:0] m;
        m = p[27] ? 28'(-p) : 28'(p);
        if (m > `FULL_SCALE_POWER)
            m = `FULL_SCALE_POWER;
        return m;
    endfunction

    logic a_within;   // First quantity inside its threshold
    logic b_within;   // Second quantity inside its threshold
    logic disabled;   // Circuit switched off by negative threshold

    // Negative threshold can never be met, so it reads as not within
    assign a_within = !thr_a[27] && (magnitude(power_a) <= 28'(thr_a)); // RULE_04
    assign b_within = !thr_b[27] && (magnitude(power_b) <= 28'(thr_b));
    assign disabled = thr_a[27] && (thr_b[27] || !use_b);  // RULE_03 RULE_14

    // Quantity a, and quantity b when use_b is set, must be inside for no-load
    assign noload = circuit_on && !disabled && a_within
                    && (b_within || !use_b);  // RULE_01 RULE_10 RULE_13

endmodule

// File: hdl/noload_status_bank.sv
// Per-phase flags and one sticky status bit for one no-load circuit.
// Assumes eval is a one-cycle pulse on the same clock.
`timescale 1ns/1ns

module noload_status_bank
    import noload_pkg::*;
#(
    parameter int PHASES = 3
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Evaluation
    input  wire logic              eval,
    input  wire logic [PHASES-1:0] next_flags,
    // Software controls
    input  wire logic              clear,
    // State
    output logic [PHASES-1:0]      flags,
    output logic                   status
);

    logic changed;  // Any phase entered or left no-load

    assign changed = eval && (next_flags != flags);  // RULE_21

    // ----------------------------------------------------------------
    // Per-phase flags, refreshed on each power result
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags <= '0;
        else if (eval)
            flags <= next_flags;  // RULE_07
    end

    // ----------------------------------------------------------------
    // Sticky status; a new event beats a same-cycle clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            status <= 1'b0;
        else if (changed)
            status <= 1'b1;  // RULE_20
        else if (clear)
            status <= 1'b0;  // RULE_19
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_change_sets_both: // RULE_21
    assert property (changed |=> status && flags == $past(next_flags))
        else $error("flag change did not set status with new flags");

    a_status_holds: // RULE_19
    assert property (status && !clear |=> status)
        else $error("status dropped without a clear");

endmodule

// File: hdl/no_load_detector.sv
// Three-circuit per-phase no-load detector with its registers.
// Assumes power results and register requests arrive on clk, one cycle
// wide, from the processing core and the serial port logic.
`timescale 1ns/1ns

module no_load_detector
    import noload_pkg::*;
#(
    parameter int  PHASES     = 3,
    parameter bit  FUND_ENABLE = 1'b1  // Fullest variant has fundamental
)
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Power results from the processing core
    input  wire logic                        power_valid,
    input  wire phase_power_type [PHASES-1:0] phase_power,
    // Register port
    input  wire reg_req_type                 reg_req,
    output logic [31:0]                      reg_rdata,
    output logic                             reg_rvalid,
    // Energy accumulation enables per phase
    output logic [PHASES-1:0]                total_acc_en,
    output logic [PHASES-1:0]                fund_acc_en,
    output logic [PHASES-1:0]                apparent_acc_en,
    // Interrupt line, active low
    output logic                             second_irq_line_n
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int CIRCUITS = 3;  // Total, fundamental, apparent

    logic [23:0] active_noload_threshold;     // Active threshold
    logic [23:0] reactive_noload_threshold;   // Reactive threshold
    logic [23:0] apparent_noload_threshold;   // Apparent threshold
    logic [2:0]  second_mask_reg;             // Interrupt mask
    logic [2:0]  second_status_reg;           // Sticky status
    logic [8:0]  phase_noload_reg;            // All phase flags

    logic signed [27:0] active_thr_ext;       // Sign extended active
    logic signed [27:0] reactive_thr_ext;     // Sign extended reactive
    logic signed [27:0] apparent_thr_ext;     // Sign extended apparent

    logic [PHASES-1:0] total_noload_now;      // Comparator results
    logic [PHASES-1:0] fund_noload_now;
    logic [PHASES-1:0] apparent_noload_now;

    logic [CIRCUITS-1:0][PHASES-1:0] next_flags;  // Per circuit inputs
    logic [CIRCUITS-1:0][PHASES-1:0] flags;       // Per circuit flags
    logic [CIRCUITS-1:0]             status_clear; // Write-one clears

    logic [PHASES-1:0] total_phase_noload_flags;
    logic [PHASES-1:0] fund_phase_noload_flags;
    logic [PHASES-1:0] apparent_phase_noload_flags;

    logic wr_active;    // Write strobes per register
    logic wr_reactive;
    logic wr_apparent;
    logic wr_status;
    logic wr_mask;

    // ----------------------------------------------------------------
    // Threshold scaling into the DSP width
    // ----------------------------------------------------------------
    // The 24-bit value widens to 28 bits by its sign
    assign active_thr_ext   = {{4{active_noload_threshold[23]}},
                               active_noload_threshold};    // RULE_05
    assign reactive_thr_ext = {{4{reactive_noload_threshold[23]}},
                               reactive_noload_threshold};  // RULE_05
    assign apparent_thr_ext = {{4{apparent_noload_threshold[23]}},
                               apparent_noload_threshold};  // RULE_18

    // ----------------------------------------------------------------
    // Comparators, three per phase
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PHASES; p++)
        begin : g_phase
            // Total active and reactive against shared thresholds
            noload_compare u_total (
                .power_a    (phase_power[p].total_act),
                .power_b    (phase_power[p].total_react),
                .thr_a      (active_thr_ext),
                .thr_b      (reactive_thr_ext),
                .use_b      (1'b1),
                .circuit_on (1'b1),
                .noload     (total_noload_now[p])
            );
            // Fundamental reuses the total thresholds
            noload_compare u_fund (
                .power_a    (phase_power[p].fund_act),
                .power_b    (phase_power[p].fund_react),
                .thr_a      (active_thr_ext),
                .thr_b      (reactive_thr_ext),
                .use_b      (1'b1),
                .circuit_on (FUND_ENABLE),
                .noload     (fund_noload_now[p])
            );
            // Apparent has a single quantity
            noload_compare u_apparent (
                .power_a    (phase_power[p].apparent),
                .power_b    (28'sh000_0000),
                .thr_a      (apparent_thr_ext),
                .thr_b      (apparent_thr_ext),
                .use_b      (1'b0),
                .circuit_on (1'b1),
                .noload     (apparent_noload_now[p])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Flag and status banks, one per circuit
    // ----------------------------------------------------------------
    assign next_flags[`STAT_TOTAL_BIT]    = total_noload_now;
    assign next_flags[`STAT_FUND_BIT]     = fund_noload_now;
    assign next_flags[`STAT_APPARENT_BIT] = apparent_noload_now;

    genvar c;
    generate
        for (c = 0; c < CIRCUITS; c++)
        begin : g_circuit
            // Flags and status bit move on the same edge
            noload_status_bank #(
                .PHASES     (PHASES)
            ) u_bank (
                .clk        (clk),
                .rst_n      (rst_n),
                .eval       (power_valid),
                .next_flags (next_flags[c]),
                .clear      (status_clear[c]),
                .flags      (flags[c]),
                .status     (second_status_reg[c])
            ); // RULE_06 RULE_11 RULE_15
        end
    endgenerate

    assign total_phase_noload_flags    = flags[`STAT_TOTAL_BIT];
    assign fund_phase_noload_flags     = flags[`STAT_FUND_BIT];
    assign apparent_phase_noload_flags = flags[`STAT_APPARENT_BIT];

    // Phase A lowest, phase C highest in each field
    assign phase_noload_reg = {apparent_phase_noload_flags,
                               fund_phase_noload_flags,
                               total_phase_noload_flags};  // RULE_07

    // ----------------------------------------------------------------
    // Energy gating
    // ----------------------------------------------------------------
    // A phase in no-load neither accumulates nor feeds pulse output
    assign total_acc_en    = ~total_phase_noload_flags;     // RULE_02
    assign fund_acc_en     = ~fund_phase_noload_flags;      // RULE_10
    assign apparent_acc_en = ~apparent_phase_noload_flags;  // RULE_13

    // ----------------------------------------------------------------
    // Register write decode
    // ----------------------------------------------------------------
    always_comb
    begin
        wr_active   = 1'b0;
        wr_reactive = 1'b0;
        wr_apparent = 1'b0;
        wr_status   = 1'b0;
        wr_mask     = 1'b0;
        if (!reg_req.wr)
            wr_active = 1'b0;  // No write this cycle
        else if (reg_req.addr == `REG_ACTIVE_THR)
            wr_active = 1'b1;
        else if (reg_req.addr == `REG_REACTIVE_THR)
            wr_reactive = 1'b1;
        else if (reg_req.addr == `REG_APPARENT_THR)
            wr_apparent = 1'b1;
        else if (reg_req.addr == `REG_SECOND_STATUS)
            wr_status = 1'b1;
        else if (reg_req.addr == `REG_SECOND_MASK)
            wr_mask = 1'b1;
    end

    // Writing one clears that status bit, zero leaves it
    assign status_clear = wr_status ? reg_req.wdata[2:0] : 3'h0;  // RULE_19

    // ----------------------------------------------------------------
    // Threshold registers
    // ----------------------------------------------------------------
    // Only the low 24 bits are stored; the rest rebuild on read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_noload_threshold   <= `THR_RESET;
            reactive_noload_threshold <= `THR_RESET;
            apparent_noload_threshold <= `THR_RESET;
        end
        else
        begin
            if (wr_active)
                active_noload_threshold <= reg_req.wdata[23:0];
            if (wr_reactive)
                reactive_noload_threshold <= reg_req.wdata[23:0];
            if (wr_apparent)
                apparent_noload_threshold <= reg_req.wdata[23:0];
        end
    end

    // ----------------------------------------------------------------
    // Mask register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            second_mask_reg <= `MASK_RESET;
        else if (wr_mask)
            second_mask_reg <= reg_req.wdata[2:0];
    end

    // ----------------------------------------------------------------
    // Read data, one cycle after the request
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (!reg_req.rd)
            reg_rdata <= reg_rdata;  // Hold last answer
        else if (reg_req.addr == `REG_ACTIVE_THR)
            reg_rdata <= {4'h0, active_thr_ext};    // RULE_05
        else if (reg_req.addr == `REG_REACTIVE_THR)
            reg_rdata <= {4'h0, reactive_thr_ext};  // RULE_05
        else if (reg_req.addr == `REG_APPARENT_THR)
            reg_rdata <= {4'h0, apparent_thr_ext};  // RULE_18
        else if (reg_req.addr == `REG_SECOND_STATUS)
            reg_rdata <= {29'h0, second_status_reg};
        else if (reg_req.addr == `REG_SECOND_MASK)
            reg_rdata <= {29'h0, second_mask_reg};
        else if (reg_req.addr == `REG_PHASE_NOLOAD)
            reg_rdata <= {23'h0, phase_noload_reg};
        else
            reg_rdata <= 32'h0000_0000;  // Unmapped reads zero
    end

    // Answer strobe follows each read request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rvalid <= 1'b0;
        else
            reg_rvalid <= reg_req.rd;
    end

    // ----------------------------------------------------------------
    // Interrupt line
    // ----------------------------------------------------------------
    // Registered so the pin never glitches on decode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            second_irq_line_n <= 1'b1;
        else
            second_irq_line_n <= ~|(second_status_reg & second_mask_reg);
            // RULE_08 RULE_12 RULE_16 RULE_19
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_irq_low_masked: // RULE_08
    assert property (second_status_reg[0] && second_mask_reg[0]
                     |=> !second_irq_line_n)
        else $error("total no-load status did not pull line low");

    a_irq_fund_low: // RULE_12
    assert property (second_status_reg[1] && second_mask_reg[1]
                     |=> !second_irq_line_n)
        else $error("fundamental status did not pull line low");

    a_irq_app_low: // RULE_16
    assert property (second_status_reg[2] && second_mask_reg[2]
                     |=> !second_irq_line_n)
        else $error("apparent status did not pull line low");

    a_irq_high_idle: // RULE_19
    assert property (!(|(second_status_reg & second_mask_reg))
                     |=> second_irq_line_n)
        else $error("line low with no unmasked status");

    a_status_ignores_mask: // RULE_20
    assert property (power_valid && total_noload_now[0]
                     != total_phase_noload_flags[0]
                     |=> second_status_reg[0])
        else $error("status not set on phase A total change");

    a_total_gate: // RULE_02
    assert property (power_valid && total_noload_now[1]
                     |=> !total_acc_en[1] ##1 !total_acc_en[1]
                         || $past(power_valid, 1) || power_valid)
        else $error("phase B total energy not suppressed");

    a_total_disable: // RULE_03
    assert property (power_valid && active_noload_threshold[23]
                     && reactive_noload_threshold[23]
                     |=> total_phase_noload_flags == 3'h0)
        else $error("total circuit active with negative thresholds");

    a_apparent_disable: // RULE_14
    assert property (power_valid && apparent_noload_threshold[23]
                     |=> apparent_phase_noload_flags == 3'h0)
        else $error("apparent circuit active with negative threshold");

    a_thr_readback: // RULE_05
    assert property (reg_req.rd && reg_req.addr == `REG_ACTIVE_THR
                     && !wr_active
                     |=> reg_rvalid && reg_rdata[31:28] == 4'h0
                         && reg_rdata[27:24] == {4{reg_rdata[23]}})
        else $error("threshold readback not padded and extended");

    a_w1c_clear: // RULE_19
    assert property (wr_status && reg_req.wdata[2] && !power_valid
                     |=> !second_status_reg[2])
        else $error("write one did not clear apparent status");

    c_total_entry:
    cover property (power_valid && total_noload_now != 3'h0
                    ##1 !second_irq_line_n);

    c_apparent_exit:
    cover property (apparent_phase_noload_flags[2] && power_valid
                    && !apparent_noload_now[2]);

    c_clear_race:
    cover property (wr_status && reg_req.wdata[0] && power_valid
                    && total_noload_now != total_phase_noload_flags);

    // Status raised with its mask bit clear: line may stay high
    c_masked_event:
    cover property (power_valid && apparent_noload_now != 3'h0
                    && !second_mask_reg[2] ##2 second_irq_line_n);

endmodule

// File: testbench/noload_host.sv
// Host model: issues register requests one at a time on clk.
// Assumes read answers arrive a fixed edge after the request.
`timescale 1ns/1ns

module noload_host
    import noload_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Register port
    output reg_req_type      reg_req,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid,
    // Read answer never came
    output logic             tmo
);
    initial
    begin
        reg_req = '0;
        tmo     = 1'b0;
    end

    // Write: strobe held for one sampling edge only
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
    endtask

    // Read: bounded wait, so a dead port cannot hang the run
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int   i;
        logic got;
        got = 1'b0;
        d   = '0;
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk);
        reg_req <= '0;
        // Answer stands for one cycle right after the taking edge
        for (i = 0; i < 4 && !got; i++)
        begin
            #1;
            got = reg_rvalid;
            d   = reg_rdata;
            @(posedge clk);
        end
        if (!got)
            tmo = 1'b1;
    endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench of the no-load detector, random plus corners.
// Assumes the host model drives every register access.
`timescale 1ns/1ns

module tb_top
    import noload_pkg::*;
;
    logic                  clk, rst_n, power_valid, reg_rvalid, irq_n;
    phase_power_type [2:0] phase_power, np;
    reg_req_type           reg_req;
    logic [31:0]           reg_rdata, v;
    logic [2:0]            t_en, f_en, a_en, mask, st, pt, pf, pa, nt, nf, na;
    logic signed [23:0]    ta, tr, tv;
    int                    error_cnt, n_tests, seed, i, p;

    no_load_detector no_load_detector_inst (.clk(clk), .rst_n(rst_n),
        .power_valid(power_valid), .phase_power(phase_power),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .total_acc_en(t_en), .fund_acc_en(f_en), .apparent_acc_en(a_en),
        .second_irq_line_n(irq_n));
    noload_host noload_host_inst (.clk(clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tmo());

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        $display("errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // Register read, a dead port ends the run
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        noload_host_inst.rd(a, v);
        if (noload_host_inst.tmo)
        begin
            error_cnt++;
            close_out();
        end
        else
            chk("register", e, v);
    endtask

    // Magnitude within threshold; a negative threshold is never met
    function automatic logic nl(input logic signed [27:0] x,
                                input logic signed [23:0] t);
        return ((x < 0) ? -x : x) <= 28'(t);
    endfunction

    function automatic logic signed [27:0] rnd();
        return 28'($random(seed) % 20000);
    endfunction

    initial
    begin
        seed = 69478;
        error_cnt = 0;
        n_tests = 0;
        power_valid = 1'b0;
        phase_power = '0;
        pt = '0; pf = '0; pa = '0;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("irq", 32'h1, 32'(irq_n));
        chk("acc_en", 32'h1ff, 32'({a_en, f_en, t_en}));
        rdc(4'h4, 32'h0000_0000);
        rdc(4'h3, 32'h0000_0000);
        rdc(4'h0, 32'h0000_0000);
        noload_host_inst.wr(4'h1, 32'h0080_0000);
        rdc(4'h1, 32'h0f80_0000);
        noload_host_inst.wr(4'h2, 32'h00ff_ff00);
        rdc(4'h2, 32'h0fff_ff00);
        noload_host_inst.wr(4'h5, 32'h0000_01ff);
        rdc(4'h5, 32'h0000_0000);
        rdc(4'h9, 32'h0000_0000);
        for (i = 0; i < 30; i++)
        begin
            ta = 24'($random(seed)) & 24'h00_3fff;
            tr = 24'($random(seed)) & 24'h00_3fff;
            tv = (i % 6 == 4) ? -24'sd1 : 24'($random(seed)) & 24'h00_3fff;
            if (i % 6 == 5)
            begin
                ta = -ta - 1;
                tr = -tr - 1;
            end
            mask = 3'($random(seed));
            noload_host_inst.wr(4'h0, {8'h00, ta});
            noload_host_inst.wr(4'h1, {8'h00, tr});
            noload_host_inst.wr(4'h2, {8'h00, tv});
            noload_host_inst.wr(4'h4, {29'h0, mask});
            noload_host_inst.wr(4'h3, 32'h0000_0007);
            @(posedge clk);
            #1 chk("irq", 32'h1, 32'(irq_n));
            for (p = 0; p < 3; p++)
            begin
                np[p] = '{rnd(), rnd(), rnd(), rnd(), rnd()};
                nt[p] = nl(np[p].total_act, ta) && nl(np[p].total_react, tr);
                nf[p] = nl(np[p].fund_act, ta) && nl(np[p].fund_react, tr);
                na[p] = nl(np[p].apparent, tv);
            end
            @(posedge clk);
            power_valid <= 1'b1;
            phase_power <= np;
            @(posedge clk);
            power_valid <= 1'b0;
            #1 chk("acc_en", 32'({~na, ~nf, ~nt}), 32'({a_en, f_en, t_en}));
            st = {|(na ^ pa), |(nf ^ pf), |(nt ^ pt)};
            @(posedge clk);
            #1 chk("irq", 32'(~|(st & mask)), 32'(irq_n));
            rdc(4'h3, 32'(st));
            rdc(4'h5, 32'({na, nf, nt}));
            chk("irq", 32'(~|(st & mask)), 32'(irq_n));
            pt = nt;
            pf = nf;
            pa = na;
        end
        close_out();
    end
endmodule
